/* File: rtl/twowire_pkg.sv */
package twowire_pkg;
	localparam int WORD_BITS = 8;
	localparam int ZONE_COUNT = 4;
	localparam int ZONE_BYTES = 32;
	localparam int ADDR_BITS = 7;
	localparam int CLK_PERIOD_NS = 20;
	localparam int INTERNAL_WRITE_DURATION_MS = 5;
	localparam int INTERNAL_WRITE_DURATION_MAX_MS = 7;
	localparam int INTERNAL_WRITE_DURATION_CYCLES =
		INTERNAL_WRITE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SCL_PERIOD_NS = 1000;
	localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int POWERUP_PULSES = 5;
	localparam int RECOVERY_CLOCKS = 9;
	localparam logic [7:0] MEM_RESET_BYTE = 8'hff;
	localparam logic [7:0] DENIED_BYTE = 8'hff;
	// select codes are arbitrary; the device looks only at bit 0
	localparam logic [7:0] SELECT_WRITE = 8'hb0;
	localparam logic [7:0] SELECT_READ = 8'hb1;
endpackage

/* File: rtl/twowire_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface twowire_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	// open drain: an enabled driver pulls low only, the pull-up gives the high
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

/* File: rtl/twowire_device.sv */
`timescale 1ns/1ps
`default_nettype none
module twowire_device
	import twowire_pkg::*;
#(
	parameter int WRITE_CYCLES = INTERNAL_WRITE_DURATION_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	twowire_if.device       link,
	input  wire logic       mode_pin,
	input  wire logic [3:0] zone_grant,
	input  wire logic [7:0] zone_rights,
	input  wire logic       rx_ready,
	output logic            rx_valid,
	output logic [6:0]      rx_addr,
	output logic [7:0]      rx_data,
	output logic            busy,
	output logic            standby,
	output logic            sync_mode
);
	typedef enum logic [4:0] {
		D_IDLE = 5'b00001,
		D_RECV = 5'b00010,
		D_ACK  = 5'b00100,
		D_SEND = 5'b01000,
		D_RACK = 5'b10000
	} dev_state_type;
	localparam int MEM_BYTES = ZONE_COUNT * ZONE_BYTES;
	localparam int TIMER_BITS = $clog2(WRITE_CYCLES + 1);

	logic                  scl_meta_reg, scl_s_reg, scl_d_reg;
	logic                  sda_meta_reg, sda_s_reg, sda_d_reg;
	logic                  mode_meta_reg, mode_s_reg;
	logic                  scl_rise, scl_fall, start_seen, stop_seen, pop;
	dev_state_type         state_reg, state_next;
	logic [3:0]            bit_reg, bit_next;
	logic [7:0]            shift_reg, shift_next;
	logic [1:0]            idx_reg, idx_next;
	logic                  rw_reg, rw_next;
	logic [ADDR_BITS-1:0]  ptr_reg, ptr_next;
	logic                  oe_reg, oe_next;
	logic                  hack_reg, hack_next;
	logic                  wrote_reg, wrote_next;
	logic                  standby_reg, standby_next;
	logic                  busy_reg, busy_next;
	logic [TIMER_BITS-1:0] timer_reg, timer_next;
	logic [1:0]            settle_reg, settle_next;
	logic                  sync_mode_reg, sync_mode_next;
	logic                  push, ack;
	logic                  head_v_reg, head_v_next, tail_v_reg, tail_v_next;
	logic [6:0]            head_a_reg, head_a_next, tail_a_reg, tail_a_next;
	logic [7:0]            head_d_reg, head_d_next, tail_d_reg, tail_d_next;
	logic [7:0]            mem_reg [MEM_BYTES];
	logic [7:0]            mem_next [MEM_BYTES];
	logic                  sda_o_reg;

	// a zone boundary is crossed only into a zone of the same rights
	function automatic logic [6:0] advance(input logic [6:0] p, input logic [7:0] rights);
		logic [1:0] z;
		logic [1:0] nz;
		z = p[6:5];
		nz = z + 2'd1;
		if (p[4:0] != 5'h1f)
			advance = p + 7'd1;
		else if (nz != 2'd0 && rights[nz*2 +: 2] == rights[z*2 +: 2])
			advance = {nz, 5'h00};
		else
			advance = {z, 5'h00};
	endfunction

	function automatic logic [7:0] fetch(input logic [6:0] p, input logic [3:0] grant,
		input logic [7:0] data);
		fetch = grant[p[6:5]] ? data : DENIED_BYTE;
	endfunction

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_meta_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			mode_meta_reg <= 1'b0;
			mode_s_reg <= 1'b0;
		end else begin
			scl_meta_reg <= link.scl;
			scl_s_reg <= scl_meta_reg;
			scl_d_reg <= scl_s_reg;
			sda_meta_reg <= link.sda;
			sda_s_reg <= sda_meta_reg;
			sda_d_reg <= sda_s_reg;
			mode_meta_reg <= mode_pin;
			mode_s_reg <= mode_meta_reg;
		end
	end

	assign scl_rise = scl_s_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s_reg & scl_d_reg;
	// data edges while the clock stays high are framing, never data
	assign start_seen = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
	assign stop_seen = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
	assign pop = head_v_reg & rx_ready;

	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		idx_next = idx_reg;
		rw_next = rw_reg;
		ptr_next = ptr_reg;
		oe_next = oe_reg;
		hack_next = hack_reg;
		wrote_next = wrote_reg;
		standby_next = standby_reg;
		busy_next = busy_reg;
		timer_next = timer_reg;
		settle_next = settle_reg;
		sync_mode_next = sync_mode_reg;
		push = 1'b0;
		ack = 1'b0;
		if (settle_reg != 2'd3)
			settle_next = settle_reg + 2'd1;
		if (settle_reg == 2'd2)
			sync_mode_next = mode_s_reg;
		if (busy_reg) begin
			if (timer_reg == '0)
				busy_next = 1'b0;
			else
				timer_next = timer_reg - 1'b1;
		end
		if (!sync_mode_reg) begin
			state_next = D_IDLE;
			oe_next = 1'b0;
		end else if (start_seen) begin
			state_next = D_RECV;
			bit_next = 4'd0;
			idx_next = 2'd0;
			oe_next = 1'b0;
			standby_next = 1'b0;
		end else if (stop_seen) begin
			state_next = D_IDLE;
			oe_next = 1'b0;
			standby_next = rw_reg;
			wrote_next = 1'b0;
			if (wrote_reg) begin
				busy_next = 1'b1;
				timer_next = TIMER_BITS'(WRITE_CYCLES - 1);
			end
		end else begin
			unique case (state_reg)
				D_IDLE: begin
				end
				D_RECV: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s_reg};
						bit_next = bit_reg + 4'd1;
					end else if (scl_fall && bit_reg == 4'd8) begin
						if (idx_reg == 2'd0) begin
							rw_next = shift_reg[0];
							ack = ~busy_reg;
						end else if (idx_reg == 2'd1) begin
							ptr_next = shift_reg[6:0];
							ack = zone_grant[shift_reg[6:5]];
						end else begin
							// a full buffer refuses the word instead of losing it
							ack = zone_grant[ptr_reg[6:5]] & ~tail_v_reg;
							push = ack;
							if (ack) begin
								ptr_next = advance(ptr_reg, zone_rights);
								wrote_next = 1'b1;
							end
						end
						if (ack) begin
							state_next = D_ACK;
							oe_next = 1'b1;
						end else
							state_next = D_IDLE;
					end
				end
				D_ACK: begin
					if (scl_fall) begin
						oe_next = 1'b0;
						bit_next = 4'd0;
						if (rw_reg) begin
							shift_next = fetch(ptr_reg, zone_grant, mem_reg[ptr_reg]);
							oe_next = ~shift_next[7];
							state_next = D_SEND;
						end else begin
							state_next = D_RECV;
							if (idx_reg != 2'd2)
								idx_next = idx_reg + 2'd1;
						end
					end
				end
				D_SEND: begin
					if (scl_rise)
						bit_next = bit_reg + 4'd1;
					else if (scl_fall) begin
						if (bit_reg == 4'd8) begin
							oe_next = 1'b0;
							state_next = D_RACK;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							oe_next = ~shift_reg[6];
						end
					end
				end
				D_RACK: begin
					if (scl_rise)
						hack_next = ~sda_s_reg;
					else if (scl_fall) begin
						bit_next = 4'd0;
						if (hack_reg) begin
							ptr_next = advance(ptr_reg, zone_rights);
							shift_next = fetch(ptr_next, zone_grant, mem_reg[ptr_next]);
							oe_next = ~shift_next[7];
							state_next = D_SEND;
						end else
							state_next = D_IDLE;
					end
				end
			endcase
		end
	end

	always_comb begin
		head_v_next = head_v_reg;
		head_a_next = head_a_reg;
		head_d_next = head_d_reg;
		tail_v_next = tail_v_reg;
		tail_a_next = tail_a_reg;
		tail_d_next = tail_d_reg;
		mem_next = mem_reg;
		if (pop) begin
			// limitation: a read of a byte still queued here sees the old value
			mem_next[head_a_reg] = head_d_reg;
			head_v_next = tail_v_reg;
			head_a_next = tail_a_reg;
			head_d_next = tail_d_reg;
			tail_v_next = 1'b0;
		end
		if (push) begin
			if (!head_v_next) begin
				head_v_next = 1'b1;
				head_a_next = ptr_reg;
				head_d_next = shift_reg;
			end else begin
				tail_v_next = 1'b1;
				tail_a_next = ptr_reg;
				tail_d_next = shift_reg;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= D_IDLE;
			bit_reg <= 4'd0;
			shift_reg <= 8'h00;
			idx_reg <= 2'd0;
			rw_reg <= 1'b0;
			ptr_reg <= 7'h00;
			oe_reg <= 1'b0;
			hack_reg <= 1'b0;
			wrote_reg <= 1'b0;
			standby_reg <= 1'b0;
			busy_reg <= 1'b0;
			timer_reg <= '0;
			settle_reg <= 2'd0;
			sync_mode_reg <= 1'b0;
			head_v_reg <= 1'b0;
			head_a_reg <= 7'h00;
			head_d_reg <= 8'h00;
			tail_v_reg <= 1'b0;
			tail_a_reg <= 7'h00;
			tail_d_reg <= 8'h00;
			mem_reg <= '{default: MEM_RESET_BYTE};
			sda_o_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			idx_reg <= idx_next;
			rw_reg <= rw_next;
			ptr_reg <= ptr_next;
			oe_reg <= oe_next;
			hack_reg <= hack_next;
			wrote_reg <= wrote_next;
			standby_reg <= standby_next;
			busy_reg <= busy_next;
			timer_reg <= timer_next;
			settle_reg <= settle_next;
			sync_mode_reg <= sync_mode_next;
			head_v_reg <= head_v_next;
			head_a_reg <= head_a_next;
			head_d_reg <= head_d_next;
			tail_v_reg <= tail_v_next;
			tail_a_reg <= tail_a_next;
			tail_d_reg <= tail_d_next;
			mem_reg <= mem_next;
			sda_o_reg <= 1'b0;
		end
	end

	assign link.dev_sda_o = sda_o_reg;
	assign link.dev_sda_oe = oe_reg;
	assign rx_valid = head_v_reg;
	assign rx_addr = head_a_reg;
	assign rx_data = head_d_reg;
	assign busy = busy_reg;
	assign standby = standby_reg;
	assign sync_mode = sync_mode_reg;
endmodule
`default_nettype wire

/* File: rtl/twowire_host.sv */
`timescale 1ns/1ps
`default_nettype none
module twowire_host
	import twowire_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	twowire_if.host         link,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_read,
	input  wire logic [6:0] cmd_addr,
	input  wire logic [7:0] cmd_data,
	output logic            cmd_ready,
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	output logic            done,
	output logic            nack
);
	typedef enum logic [4:0] {
		H_INIT  = 5'b00001,
		H_IDLE  = 5'b00010,
		H_START = 5'b00100,
		H_BIT   = 5'b01000,
		H_STOP  = 5'b10000
	} host_state_type;
	typedef enum logic [5:0] {
		S_RECOV = 6'b000001,
		S_SELW  = 6'b000010,
		S_ADDR  = 6'b000100,
		S_DATA  = 6'b001000,
		S_SELR  = 6'b010000,
		S_READ  = 6'b100000
	} stage_type;
	localparam int QBITS = $clog2(SCL_QUARTER_CYCLES);

	logic             sda_meta_reg, sda_s_reg;
	logic             tick;
	host_state_type   state_reg, state_next;
	stage_type        stage_reg, stage_next;
	logic [QBITS-1:0] qcnt_reg, qcnt_next;
	logic [1:0]       q_reg, q_next;
	logic [3:0]       bit_reg, bit_next;
	logic [7:0]       tx_reg, tx_next, rx_reg, rx_next;
	logic             scl_reg, scl_next, oe_reg, oe_next;
	logic             read_reg, read_next;
	logic [6:0]       addr_reg, addr_next;
	logic [7:0]       data_reg, data_next;
	logic             ready_reg, ready_next, rdv_reg, rdv_next;
	logic [7:0]       rdd_reg, rdd_next;
	logic             done_reg, done_next, nack_reg, nack_next;
	logic             sda_o_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sda_meta_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end else begin
			sda_meta_reg <= link.sda;
			sda_s_reg <= sda_meta_reg;
		end
	end

	// quarters: 0 clock low, 1 data set, 2 clock high, 3 sample or framing edge
	always_comb begin
		state_next = state_reg;
		stage_next = stage_reg;
		qcnt_next = qcnt_reg;
		q_next = q_reg;
		bit_next = bit_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		scl_next = scl_reg;
		oe_next = oe_reg;
		read_next = read_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		ready_next = ready_reg;
		rdv_next = 1'b0;
		rdd_next = rdd_reg;
		done_next = 1'b0;
		nack_next = nack_reg;
		tick = qcnt_reg == QBITS'(SCL_QUARTER_CYCLES - 1);
		if (state_reg != H_IDLE) begin
			qcnt_next = tick ? '0 : qcnt_reg + 1'b1;
			if (tick)
				q_next = q_reg + 2'd1;
		end
		unique case (state_reg)
			H_IDLE: begin
				if (cmd_valid && ready_reg) begin
					ready_next = 1'b0;
					read_next = cmd_read;
					addr_next = cmd_addr;
					data_next = cmd_data;
					nack_next = 1'b0;
					stage_next = S_SELW;
					state_next = H_START;
				end
			end
			H_INIT: begin
				if (tick) begin
					if (q_reg == 2'd0)
						scl_next = 1'b0;
					else if (q_reg == 2'd2)
						scl_next = 1'b1;
					else if (q_reg == 2'd3) begin
						bit_next = bit_reg + 4'd1;
						// early pulses flush power-up, later ones free a stuck line
						if ((bit_reg >= 4'(POWERUP_PULSES) && sda_s_reg) ||
							bit_reg == 4'(POWERUP_PULSES + RECOVERY_CLOCKS - 1)) begin
							stage_next = S_RECOV;
							state_next = H_START;
						end
					end
				end
			end
			H_START: begin
				if (tick) begin
					if (q_reg == 2'd0)
						scl_next = 1'b0;
					else if (q_reg == 2'd1)
						oe_next = 1'b0;
					else if (q_reg == 2'd2)
						scl_next = 1'b1;
					else begin
						oe_next = 1'b1;
						bit_next = 4'd0;
						tx_next = (stage_reg == S_SELR) ? SELECT_READ : SELECT_WRITE;
						state_next = (stage_reg == S_RECOV) ? H_STOP : H_BIT;
					end
				end
			end
			H_BIT: begin
				if (tick) begin
					if (q_reg == 2'd0)
						scl_next = 1'b0;
					else if (q_reg == 2'd1)
						oe_next = bit_reg != 4'd8 && stage_reg != S_READ && ~tx_reg[7];
					else if (q_reg == 2'd2)
						scl_next = 1'b1;
					else if (bit_reg != 4'd8) begin
						rx_next = {rx_reg[6:0], sda_s_reg};
						tx_next = {tx_reg[6:0], 1'b0};
						bit_next = bit_reg + 4'd1;
					end else begin
						bit_next = 4'd0;
						if (stage_reg != S_READ && sda_s_reg) begin
							nack_next = 1'b1;
							state_next = H_STOP;
						end else begin
							unique case (stage_reg)
								S_SELW: begin
									stage_next = S_ADDR;
									tx_next = {1'b0, addr_reg};
								end
								S_ADDR: begin
									stage_next = read_reg ? S_SELR : S_DATA;
									tx_next = data_reg;
									if (read_reg)
										state_next = H_START;
								end
								S_SELR:
									stage_next = S_READ;
								S_READ: begin
									rdv_next = 1'b1;
									rdd_next = rx_reg;
									state_next = H_STOP;
								end
								default:
									state_next = H_STOP;
							endcase
						end
					end
				end
			end
			H_STOP: begin
				if (tick) begin
					if (q_reg == 2'd0)
						scl_next = 1'b0;
					else if (q_reg == 2'd1)
						oe_next = 1'b1;
					else if (q_reg == 2'd2)
						scl_next = 1'b1;
					else begin
						oe_next = 1'b0;
						done_next = 1'b1;
						ready_next = 1'b1;
						state_next = H_IDLE;
					end
				end
			end
			default:
				state_next = H_INIT;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= H_INIT;
			stage_reg <= S_RECOV;
			qcnt_reg <= '0;
			q_reg <= 2'd0;
			bit_reg <= 4'd0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			read_reg <= 1'b0;
			addr_reg <= 7'h00;
			data_reg <= 8'h00;
			ready_reg <= 1'b0;
			rdv_reg <= 1'b0;
			rdd_reg <= 8'h00;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_o_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			stage_reg <= stage_next;
			qcnt_reg <= qcnt_next;
			q_reg <= q_next;
			bit_reg <= bit_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			scl_reg <= scl_next;
			oe_reg <= oe_next;
			read_reg <= read_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			ready_reg <= ready_next;
			rdv_reg <= rdv_next;
			rdd_reg <= rdd_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
			sda_o_reg <= 1'b0;
		end
	end

	assign link.scl = scl_reg;
	assign link.host_sda_o = sda_o_reg;
	assign link.host_sda_oe = oe_reg;
	assign cmd_ready = ready_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rdd_reg;
	assign done = done_reg;
	assign nack = nack_reg;
endmodule
`default_nettype wire

/* File: tb/twowire_props.sv */
`timescale 1ns/1ps
`default_nettype none
module twowire_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	logic       scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
	logic       frame_reg, frame_next, start_seen, stop_seen;
	logic [3:0] cnt_reg, cnt_next;
	always_comb begin
		start_seen = scl & scl_d_reg & sda_d_reg & ~sda;
		stop_seen = scl & scl_d_reg & ~sda_d_reg & sda;
		scl_d_next = scl;
		sda_d_next = sda;
		frame_next = start_seen | (frame_reg & ~stop_seen);
		cnt_next = cnt_reg;
		if (start_seen | stop_seen) begin
			cnt_next = 4'h0;
		end else if (frame_reg & scl & ~scl_d_reg) begin
			cnt_next = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			frame_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end else begin
			scl_d_reg <= scl_d_next;
			sda_d_reg <= sda_d_next;
			frame_reg <= frame_next;
			cnt_reg <= cnt_next;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_clock_high;
		##[1:100] $rose(scl) ##[1:100] $fell(scl);
	endsequence
	property p_pull_only;
		dev_sda_o == 1'b0 && host_sda_o == 1'b0;
	endproperty
	property p_dev_edge;
		$changed(dev_sda_oe) |-> !scl && !$past(scl);
	endproperty
	property p_host_edge;
		$changed(host_sda_oe) && scl && $past(scl) |-> start_seen || stop_seen;
	endproperty
	property p_start_free;
		start_seen |-> !dev_sda_oe;
	endproperty
	property p_word_frame;
		// the framing pulse's own rise follows the ack, so it counts as one
		start_seen || stop_seen |-> cnt_reg == 4'h0 || cnt_reg == 4'h1;
	endproperty
	property p_ack_ninth;
		$rose(dev_sda_oe) && cnt_reg == 4'h8 |-> dev_sda_oe throughout s_clock_high;
	endproperty
	property p_pull_in_frame;
		$rose(dev_sda_oe) |-> frame_reg;
	endproperty
	property p_quiet_stop;
		stop_seen |=> !dev_sda_oe [*8];
	endproperty
	a_pull_only: assert property (p_pull_only)
		else $error("data line driven high");
	a_dev_edge: assert property (p_dev_edge)
		else $error("device moved data while clock high");
	a_host_edge: assert property (p_host_edge)
		else $error("host moved data while clock high without framing");
	a_start_free: assert property (p_start_free)
		else $error("device pulling at start");
	a_word_frame: assert property (p_word_frame)
		else $error("framing inside a word");
	a_ack_ninth: assert property (p_ack_ninth)
		else $error("acknowledge not held over ninth clock");
	a_pull_in_frame: assert property (p_pull_in_frame)
		else $error("device pulled outside a frame");
	a_quiet_stop: assert property (p_quiet_stop)
		else $error("device pulled after stop");
endmodule
`default_nettype wire

/* File: tb/secure_eeprom_two_wire_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module secure_eeprom_two_wire_slave_tb
	import twowire_pkg::*;
();
	// long enough that a back-to-back select still meets the timer
	localparam int WCYC = 2000;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic       mode_pin = 1'b1;
	logic [3:0] zone_grant = 4'hf;
	logic [7:0] zone_rights = 8'h00;
	logic       rx_ready = 1'b0;
	logic       rx_ready_b = 1'b0;
	logic       cmd_valid = 1'b0;
	logic       cmd_read = 1'b0;
	logic [6:0] cmd_addr = 7'h00;
	logic [7:0] cmd_data = 8'h00;
	logic       bb_scl = 1'b1;
	logic       bb_oe = 1'b0;
	logic       cmd_ready, rd_valid, done, nack, rx_valid, busy, standby, sync_mode;
	logic       rx_valid_b, busy_b;
	logic [6:0] rx_addr, rx_addr_b;
	logic [7:0] rd_data, rx_data, rx_data_b, got;
	int         fail_count = 0;
	int         num_checks = 0;
	twowire_if link ();
	twowire_if link_b ();
	assign link_b.scl = bb_scl;
	assign link_b.host_sda_o = 1'b0;
	assign link_b.host_sda_oe = bb_oe;
	twowire_host u_twowire_host (.ref_clk(ref_clk), .rst(rst), .link(link),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
	twowire_device #(.WRITE_CYCLES(WCYC)) u_twowire_device (.ref_clk(ref_clk), .rst(rst),
		.link(link), .mode_pin(mode_pin), .zone_grant(zone_grant), .zone_rights(zone_rights),
		.rx_ready(rx_ready), .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_data(rx_data),
		.busy(busy), .standby(standby), .sync_mode(sync_mode));
	twowire_device #(.WRITE_CYCLES(WCYC)) u_twowire_device_b (.ref_clk(ref_clk), .rst(rst),
		.link(link_b), .mode_pin(mode_pin), .zone_grant(zone_grant), .zone_rights(zone_rights),
		.rx_ready(rx_ready_b), .rx_valid(rx_valid_b), .rx_addr(rx_addr_b), .rx_data(rx_data_b),
		.busy(busy_b), .standby(), .sync_mode());
	twowire_props u_twowire_props (.ref_clk(ref_clk), .rst(rst), .scl(link.scl),
		.host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
		.dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
	always #10 ref_clk = ~ref_clk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic host_cmd(input logic rd, input logic [6:0] a, input logic [7:0] d);
		int n;
		n = 0;
		got = 8'hxx;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_addr = a;
		cmd_data = d;
		tick(1);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			if (rd_valid === 1'b1) got = rd_data;
			tick(1);
			n++;
		end
		check(n < 4000, 1'b1);
		// flags land a few cycles after the stop on the wire
		tick(8);
	endtask
	task automatic wait_busy(input logic side_b, output int n);
		n = 0;
		while ((side_b ? busy_b : busy) === 1'b1 && n < WCYC + 100) begin
			tick(1);
			n++;
		end
	endtask
	// bench-made link clock: 160 ns period, quarters of two cycles
	task automatic bb_bit(input logic b, output logic s);
		tick(2);
		bb_oe = ~b;
		tick(2);
		bb_scl = 1'b1;
		tick(2);
		s = link_b.sda;
		tick(2);
		bb_scl = 1'b0;
	endtask
	task automatic bb_start;
		tick(2);
		bb_oe = 1'b0;
		tick(2);
		bb_scl = 1'b1;
		tick(2);
		bb_oe = 1'b1;
		tick(2);
		bb_scl = 1'b0;
	endtask
	task automatic bb_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bb_bit(d[i], s);
		bb_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic bb_write(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1);
		logic k;
		logic ok;
		int   n;
		bb_start;
		bb_byte(SELECT_WRITE, ok);
		bb_byte({1'b0, a}, k);
		ok = ok & k;
		bb_byte(d0, k);
		ok = ok & k;
		bb_byte(d1, k);
		check(ok & k, 1'b1);
		tick(2);
		bb_oe = 1'b1;
		tick(2);
		bb_scl = 1'b1;
		tick(2);
		bb_oe = 1'b0;
		tick(6);
		rx_ready_b = 1'b1;
		tick(2);
		rx_ready_b = 1'b0;
		wait_busy(1'b1, n);
	endtask
	task automatic test_power;
		logic s;
		check(sync_mode, 1'b1);
		check({busy, standby, rx_valid}, 8'h00);
		bb_scl = 1'b0;
		repeat (5) bb_bit(1'b1, s);
		tick(2);
		bb_scl = 1'b1;
		$display("test power done");
	endtask
	task automatic test_busy_buffer;
		int n;
		host_cmd(1'b0, 7'h25, 8'h5a);
		check({nack, busy, rx_valid}, 8'h03);
		check({1'b0, rx_addr}, 8'h25);
		check(rx_data, 8'h5a);
		host_cmd(1'b0, 7'h26, 8'ha5);
		check(nack, 1'b1);
		wait_busy(1'b0, n);
		host_cmd(1'b0, 7'h26, 8'ha5);
		wait_busy(1'b0, n);
		check(n >= WCYC - 60 && n <= WCYC, 1'b1);
		host_cmd(1'b0, 7'h27, 8'h33);
		check({nack, busy}, 8'h02);
		rx_ready = 1'b1;
		tick(1);
		check({1'b0, rx_addr}, 8'h26);
		check(rx_data, 8'ha5);
		tick(1);
		rx_ready = 1'b0;
		check(rx_valid, 1'b0);
		host_cmd(1'b1, 7'h25, 8'h00);
		check(got, 8'h5a);
		check(standby, 1'b1);
		$display("test busy buffer done");
	endtask
	task automatic test_deny;
		zone_grant = 4'hb;
		host_cmd(1'b0, 7'h45, 8'h99);
		check({nack, standby, rx_valid, busy}, 8'h08);
		host_cmd(1'b1, 7'h45, 8'h00);
		check(nack, 1'b1);
		zone_grant = 4'hf;
		$display("test deny done");
	endtask
	task automatic test_chain;
		for (int k = 0; k < 3; k++) begin
			zone_rights = (k == 1) ? 8'h04 : 8'h00;
			fork
				bb_write((k == 2) ? 7'h7f : 7'h1f, 8'h11, 8'h22);
				begin
					wait (rx_valid_b === 1'b1 && rx_data_b === 8'h22);
					#1;
					check({1'b0, rx_addr_b}, (k == 0) ? 8'h20 : ((k == 1) ? 8'h00 : 8'h60));
				end
			join
		end
		$display("test chain done");
	endtask
	task automatic test_abort;
		logic s;
		int   k;
		bb_start;
		bb_byte(SELECT_WRITE, s);
		repeat (4) bb_bit(1'b0, s);
		k = 0;
		do begin
			bb_bit(1'b1, s);
			k++;
		end while (s !== 1'b1 && k < 9);
		check(s, 1'b1);
		fork
			bb_write(7'h10, 8'h77, 8'h78);
			begin
				wait (rx_valid_b === 1'b1);
				#1;
				check({1'b0, rx_addr_b}, 8'h10);
				check(rx_data_b, 8'h77);
			end
		join
		check(rx_valid_b, 1'b0);
		$display("test abort done");
	endtask
	// second reset with the mode pin low: the link must be ignored
	task automatic test_mode;
		logic s;
		mode_pin = 1'b0;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(6);
		check(sync_mode, 1'b0);
		check({busy, standby, rx_valid}, 8'h00);
		bb_start;
		bb_byte(SELECT_WRITE, s);
		check(s, 1'b0);
		$display("test mode done");
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		fail_count++;
		end_sim;
	end
	initial begin
		tick(2);
		rst = 1'b0;
		tick(6);
		test_power;
		test_busy_buffer;
		test_deny;
		test_chain;
		test_abort;
		test_mode;
		end_sim;
	end
endmodule
`default_nettype wire
